// file: rtl/agu_unit.sv
// address generation unit: program counter, return stack, rom page,
// lookup pointer and data ram address selectors
// assumes the core issues at most one command per clock on the link

// Functional notes
// - 14-bit program counter gives fetch address
// - core sets rom page before jump/call
// - reset and interrupts load vector directly
// - fixed vector addresses, fast prescaler first
// - call and interrupt push counter on stack
// - return pops top of stack into counter
// - ninth push overwrites the oldest entry
// - two rom pages of 2048 words
// - branches stay in current rom page
// - table read picks nibble into ram
// - pointer from four nibbles, first is lowest
// - rom page bit 0 only, rest reserved
// - eight ram banks of 128 nibbles
// - core sets bank and page before access
// - indirect page n selects offsets n*16..+15
// - indirect page bits 2..0, bit 3 reserved
// - banks 0 and 1 double as working registers
// - working page n maps n*16..n*16+15
// - unselected pages remain plain data memory
// - immediate operands only on working registers
// - bank selector is a readable 4-bit register
// - bank bits 2..0 pick n*128, bit3 reserved
module agu_unit
  import agu_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic ce,
  agu_if.unit lnk
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [13:0] pc;
    logic [STK_DEPTH-1:0][13:0] stk;
    logic [2:0] sp;
    logic romPg;
    logic [2:0] page;
    logic [3:0] wrkPage;
    logic [2:0] bank;
    logic [3:0][3:0] tab;
    logic [4:0] pend;
    logic [4:0] irqAck;
    logic [3:0] tabNib;
    logic [9:0] ramAddr;
    logic ramWe;
    logic ramRe;
    logic immErr;
    logic done;
  } agu_unit_st_t;

  agu_unit_st_t s_q;
  agu_unit_st_t s_d;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // lowest index pending request is the highest priority
  function automatic logic [4:0] prioPick(input logic [4:0] req);
    logic [4:0] one;
    one = 5'h00;
    for (int i = NIRQ - 1; i >= 0; i--)
    begin
      if (req[i])
      begin
        one = 5'h00;
        one[i] = 1'b1;
      end
    end
    return one;
  endfunction

  function automatic logic [13:0] vecOf(input logic [4:0] one);
    logic [13:0] v;
    v = PC_RESET;
    for (int i = 0; i < NIRQ; i++)
    begin
      if (one[i])
      begin
        v = IRQ_VEC[i];
      end
    end
    return v;
  endfunction

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  logic [4:0] clr;
  logic [4:0] pick;
  logic [13:0] pcInc;
  logic [13:0] pageTarget;
  logic [13:0] localTarget;
  logic [3:0] nibSel;
  logic [3:0] op;

  always_comb
  begin
    s_d = s_q;
    clr = 5'h00;
    op = lnk.cmdOp;
    pick = prioPick(s_q.pend);
    pcInc = s_q.pc + 14'h0001;
    // jump and call land in the preselected page
    pageTarget = {s_q.pc[13:12], s_q.romPg, lnk.cmdArg[PAGE_OFS_W-1:0]};
    // conditional branches keep the page bit of the branch itself
    localTarget = {s_q.pc[13:ROM_PAGE_BIT], lnk.cmdArg[PAGE_OFS_W-1:0]};
    nibSel = {s_q.tab[0][1:0], 2'b00};
    s_d.done = 1'b0;
    s_d.ramWe = 1'b0;
    s_d.ramRe = 1'b0;
    s_d.immErr = 1'b0;
    s_d.irqAck = 5'h00;
    if (lnk.cmdValid)
    begin
      s_d.done = 1'b1;
      unique case (op)
        OP_NOP:
        begin
          s_d.pc = s_q.pc;
        end
        OP_STEP:
        begin
          s_d.pc = pcInc;
        end
        OP_JUMP:
        begin
          s_d.pc = pageTarget;
        end
        OP_CALL, OP_INTA:
        begin
          if (op == OP_CALL || s_q.pend != 5'h00)
          begin
            // the interrupted instruction is resumed, a call returns past itself
            s_d.stk[s_q.sp] = (op == OP_CALL) ? pcInc : s_q.pc;
            s_d.sp = s_q.sp + 3'd1;
            if (op == OP_CALL)
            begin
              s_d.pc = pageTarget;
            end
            else
            begin
              s_d.pc = vecOf(pick);
              clr = pick;
              s_d.irqAck = pick;
            end
          end
          else
          begin
            s_d.pc = pcInc;
          end
        end
        OP_BRANCH:
        begin
          s_d.pc = localTarget;
        end
        OP_RET:
        begin
          s_d.pc = s_q.stk[s_q.sp - 3'd1];
          s_d.sp = s_q.sp - 3'd1;
        end
        OP_SET_ROMPG:
        begin
          s_d.romPg = lnk.cmdArg[0];
        end
        OP_SET_PAGE:
        begin
          s_d.page = lnk.cmdArg[2:0];
        end
        OP_SET_WPAGE:
        begin
          s_d.wrkPage = lnk.cmdArg[3:0];
        end
        OP_SET_BANK:
        begin
          s_d.bank = lnk.cmdArg[2:0];
        end
        OP_SET_TAB:
        begin
          s_d.tab[lnk.cmdArg[5:4]] = lnk.cmdArg[3:0];
        end
        OP_TABRD:
        begin
          s_d.tabNib = lnk.romData[nibSel +: 4];
          s_d.ramAddr = {s_q.bank, lnk.cmdArg[6:0]};
          s_d.ramWe = 1'b1;
        end
        OP_DIRECT, OP_INDIRECT:
        begin
          if (lnk.cmdArg[ARG_IMM_BIT])
          begin
            s_d.immErr = 1'b1;
          end
          else
          begin
            s_d.ramRe = 1'b1;
            if (op == OP_DIRECT)
            begin
              s_d.ramAddr = {s_q.bank, lnk.cmdArg[6:0]};
            end
            else
            begin
              s_d.ramAddr = {s_q.bank, s_q.page, lnk.cmdArg[3:0]};
            end
          end
        end
        OP_WREG:
        begin
          // working registers live in banks 0 and 1 only
          s_d.ramAddr = {2'b00, s_q.wrkPage, lnk.cmdArg[3:0]};
          s_d.ramRe = 1'b1;
        end
      endcase
    end
    // a request arriving while its bit is cleared stays pending
    s_d.pend = (s_q.pend & ~clr) | lnk.irqReq;
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      s_q <= '0;
      s_q.pc <= PC_RESET;
    end
    else if (ce)
    begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign lnk.done = s_q.done;
  assign lnk.pc = s_q.pc;
  assign lnk.fetchAddr = s_q.pc[11:0];
  assign lnk.tabAddr = {s_q.tab[3][1:0], s_q.tab[2], s_q.tab[1], s_q.tab[0]};
  assign lnk.tabNib = s_q.tabNib;
  assign lnk.ramAddr = s_q.ramAddr;
  assign lnk.ramWe = s_q.ramWe;
  assign lnk.ramRe = s_q.ramRe;
  assign lnk.immErr = s_q.immErr;
  assign lnk.irqAck = s_q.irqAck;
  assign lnk.romPageRd = {3'b000, s_q.romPg};
  assign lnk.pageRd = {1'b0, s_q.page};
  assign lnk.workPageRd = s_q.wrkPage;
  assign lnk.bankRd = {1'b0, s_q.bank};

endmodule

// file: rtl/agu_pkg.sv
// constants, command codes and register map of the address generation unit
// assumes a single system clock shared by the core end and the unit
package agu_pkg;
  // --------------------------------------------------------------------
  // address widths
  // --------------------------------------------------------------------
  localparam int PC_W = 14;
  localparam int RAM_AW = 10;
  localparam int STK_DEPTH = 8;
  localparam int NIRQ = 5;
  localparam int PAGE_OFS_W = 11;
  localparam int ROM_PAGE_BIT = 11;
  localparam logic [3:0] STK_FULL = 4'h8;

  // --------------------------------------------------------------------
  // reset values and vectors, index 0 is the highest priority
  // --------------------------------------------------------------------
  localparam logic [13:0] PC_RESET = 14'h0000;
  localparam logic [3:0] SEL_RESET = 4'h0;
  localparam logic [4:0][13:0] IRQ_VEC = {14'h0020, 14'h0014, 14'h000C, 14'h0008, 14'h0004};

  // --------------------------------------------------------------------
  // command codes from the core
  // --------------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_NOP = 4'h0,
    OP_STEP = 4'h1,
    OP_JUMP = 4'h2,
    OP_CALL = 4'h3,
    OP_BRANCH = 4'h4,
    OP_RET = 4'h5,
    OP_INTA = 4'h6,
    OP_SET_ROMPG = 4'h7,
    OP_SET_PAGE = 4'h8,
    OP_SET_WPAGE = 4'h9,
    OP_SET_BANK = 4'hA,
    OP_SET_TAB = 4'hB,
    OP_TABRD = 4'hC,
    OP_DIRECT = 4'hD,
    OP_INDIRECT = 4'hE,
    OP_WREG = 4'hF
  } agu_op_t;
  // arg bit that marks an immediate operand on a memory access
  localparam int ARG_IMM_BIT = 13;

  // --------------------------------------------------------------------
  // software register map of the core end (byte offsets)
  // --------------------------------------------------------------------
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_IRQ = 8'h04;
  localparam logic [7:0] REG_ROM = 8'h08;
  localparam logic [7:0] REG_STAT = 8'h0C;
  localparam logic [7:0] REG_SEL = 8'h10;
  localparam logic [7:0] REG_RAM = 8'h14;
  localparam int CMD_ARG_LSB = 4;
  localparam int STAT_ERR_BIT = 16;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// file: rtl/agu_if.sv
// link between the core end and the address generation unit
// both ends run on the same clock; no crossing is needed
interface agu_if;
  logic cmdValid;
  logic [3:0] cmdOp;
  logic [13:0] cmdArg;
  logic [4:0] irqReq;
  logic [15:0] romData;
  logic done;
  logic [13:0] pc;
  logic [11:0] fetchAddr;
  logic [13:0] tabAddr;
  logic [3:0] tabNib;
  logic [9:0] ramAddr;
  logic ramWe;
  logic ramRe;
  logic immErr;
  logic [4:0] irqAck;
  logic [3:0] romPageRd;
  logic [3:0] pageRd;
  logic [3:0] workPageRd;
  logic [3:0] bankRd;

  modport unit (input cmdValid, cmdOp, cmdArg, irqReq, romData,
    output done, pc, fetchAddr, tabAddr, tabNib, ramAddr, ramWe, ramRe, immErr,
    irqAck, romPageRd, pageRd, workPageRd, bankRd);
  modport core (output cmdValid, cmdOp, cmdArg, irqReq, romData,
    input done, pc, fetchAddr, tabAddr, tabNib, ramAddr, ramWe, ramRe, immErr,
    irqAck, romPageRd, pageRd, workPageRd, bankRd);
endinterface

// file: rtl/agu_core_end.sv
// core end: takes orders from software over axi4-lite and drives the link
// assumes one aligned 32-bit word per register and a shared clock
module agu_core_end
  import agu_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  agu_if.core lnk
);

  typedef struct packed {
    logic awHave;
    logic [7:0] awAddr;
    logic wHave;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic awReady;
    logic wReady;
    logic bValid;
    logic [1:0] bResp;
    logic arReady;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
    logic cmdValid;
    logic [3:0] cmdOp;
    logic [13:0] cmdArg;
    logic [4:0] irqReq;
    logic [15:0] romData;
    logic errSeen;
  } agu_core_st_t;

  agu_core_st_t s_q;
  agu_core_st_t s_d;

  function automatic logic regHit(input logic [7:0] a);
    return a == REG_CMD || a == REG_IRQ || a == REG_ROM || a == REG_STAT
      || a == REG_SEL || a == REG_RAM;
  endfunction

  // ----------------------------------------------------------------------
  // bus slave and command issue
  // ----------------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    s_d.cmdValid = 1'b0;
    s_d.irqReq = 5'h00;
    if (s_axi_awvalid && s_q.awReady)
    begin
      s_d.awHave = 1'b1;
      s_d.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_q.wReady)
    begin
      s_d.wHave = 1'b1;
      s_d.wData = s_axi_wdata;
      s_d.wStrb = s_axi_wstrb;
    end
    if (s_q.bValid && s_axi_bready)
    begin
      s_d.bValid = 1'b0;
    end
    if (s_q.awHave && s_q.wHave && !s_q.bValid)
    begin
      s_d.awHave = 1'b0;
      s_d.wHave = 1'b0;
      s_d.bValid = 1'b1;
      s_d.bResp = regHit(s_q.awAddr) ? RESP_OKAY : RESP_SLVERR;
      if (s_q.awAddr == REG_CMD)
      begin
        s_d.cmdValid = 1'b1;
        s_d.cmdOp = s_q.wData[3:0];
        s_d.cmdArg = s_q.wData[CMD_ARG_LSB +: 14];
      end
      if (s_q.awAddr == REG_IRQ)
      begin
        s_d.irqReq = s_q.wData[4:0];
      end
      if (s_q.awAddr == REG_ROM)
      begin
        if (s_q.wStrb[0])
        begin
          s_d.romData[7:0] = s_q.wData[7:0];
        end
        if (s_q.wStrb[1])
        begin
          s_d.romData[15:8] = s_q.wData[15:8];
        end
      end
      if (s_q.awAddr == REG_STAT && s_q.wData[STAT_ERR_BIT])
      begin
        s_d.errSeen = 1'b0;
      end
    end
    // a refused access reported in the same cycle as a clear is kept
    if (lnk.immErr)
    begin
      s_d.errSeen = 1'b1;
    end
    if (s_q.rValid && s_axi_rready)
    begin
      s_d.rValid = 1'b0;
    end
    if (s_axi_arvalid && s_q.arReady)
    begin
      s_d.rValid = 1'b1;
      s_d.rResp = regHit(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      unique case (s_axi_araddr)
        REG_ROM: s_d.rData = {16'h0000, s_q.romData};
        REG_STAT: s_d.rData = {15'h0000, s_q.errSeen, 2'b00, lnk.pc};
        REG_SEL: s_d.rData = {16'h0000, lnk.bankRd, lnk.workPageRd, lnk.pageRd, lnk.romPageRd};
        REG_RAM: s_d.rData = {12'h000, lnk.ramRe, lnk.ramWe, lnk.tabNib, lnk.ramAddr,
          lnk.tabAddr[3:0]};
        default: s_d.rData = 32'h00000000;
      endcase
    end
    s_d.awReady = !s_d.awHave;
    s_d.wReady = !s_d.wHave;
    s_d.arReady = !s_d.rValid;
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      s_q <= '0;
    end
    else if (ce)
    begin
      s_q <= s_d;
    end
  end

  assign s_axi_awready = s_q.awReady;
  assign s_axi_wready = s_q.wReady;
  assign s_axi_bvalid = s_q.bValid;
  assign s_axi_bresp = s_q.bResp;
  assign s_axi_arready = s_q.arReady;
  assign s_axi_rvalid = s_q.rValid;
  assign s_axi_rdata = s_q.rData;
  assign s_axi_rresp = s_q.rResp;
  assign lnk.cmdValid = s_q.cmdValid;
  assign lnk.cmdOp = s_q.cmdOp;
  assign lnk.cmdArg = s_q.cmdArg;
  assign lnk.irqReq = s_q.irqReq;
  assign lnk.romData = s_q.romData;

endmodule

// file: tb/agu_chk.sv
// checker: link relations between the core end and the unit
// assumes one clock, async active low reset, ce held high by the bench
module agu_chk
  import agu_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic done,
  input wire logic cmdValid,
  input wire logic [3:0] cmdOp,
  input wire logic [13:0] cmdArg,
  input wire logic [15:0] romData,
  input wire logic [13:0] pc,
  input wire logic [11:0] fetchAddr,
  input wire logic [13:0] tabAddr,
  input wire logic [3:0] tabNib,
  input wire logic [9:0] ramAddr,
  input wire logic ramWe,
  input wire logic ramRe,
  input wire logic immErr,
  input wire logic [4:0] irqAck,
  input wire logic [3:0] romPageRd,
  input wire logic [3:0] pageRd,
  input wire logic [3:0] workPageRd,
  input wire logic [3:0] bankRd
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  // --------------------------------------------------------------------
  // command decode
  // --------------------------------------------------------------------
  logic [13:0] ackVec;
  logic [3:0] tabPick;
  wire intaCmd = cmdValid && cmdOp == OP_INTA;
  wire dirOk = cmdValid && cmdOp == OP_DIRECT && !cmdArg[13];
  wire indOk = cmdValid && cmdOp == OP_INDIRECT && !cmdArg[13];
  wire immBad = cmdValid && (cmdOp == OP_DIRECT || cmdOp == OP_INDIRECT) && cmdArg[13];
  wire jmpCmd = cmdValid && (cmdOp == OP_JUMP || cmdOp == OP_CALL);
  assign tabPick = romData[{tabAddr[1:0], 2'b00} +: 4];
  always_comb
  begin
    case (irqAck)
      5'h01: ackVec = 14'h0004;
      5'h02: ackVec = 14'h0008;
      5'h04: ackVec = 14'h000C;
      5'h08: ackVec = 14'h0014;
      5'h10: ackVec = 14'h0020;
      default: ackVec = 14'h3FFF;
    endcase
  end
  // --------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------
  property p_done; done == $past(cmdValid); endproperty
  a_done: assert property (p_done) else $error("done not one cycle after command");
  property p_fetch; fetchAddr == pc[11:0]; endproperty
  a_fetch: assert property (p_fetch) else $error("fetch address differs from pc");
  property p_step; cmdValid && cmdOp == OP_STEP |=> pc == $past(pc) + 14'h1; endproperty
  a_step: assert property (p_step) else $error("step did not add one");
  property p_jump;
    jmpCmd |=> pc == {$past(pc[13:12]), $past(romPageRd[0]), $past(cmdArg[10:0])};
  endproperty
  a_jump: assert property (p_jump) else $error("jump target page wrong");
  property p_branch;
    cmdValid && cmdOp == OP_BRANCH |=> pc == {$past(pc[13:11]), $past(cmdArg[10:0])};
  endproperty
  a_branch: assert property (p_branch) else $error("branch left its page");
  property p_vec; irqAck != 5'h0 |-> pc == ackVec && $past(intaCmd); endproperty
  a_vec: assert property (p_vec) else $error("interrupt vector wrong");
  property p_direct; dirOk |=> ramRe && ramAddr == {$past(bankRd[2:0]), $past(cmdArg[6:0])};
  endproperty
  a_direct: assert property (p_direct) else $error("direct address wrong");
  property p_indirect;
    indOk |=> ramRe && ramAddr == {$past(bankRd[2:0]), $past(pageRd[2:0]), $past(cmdArg[3:0])};
  endproperty
  a_indirect: assert property (p_indirect) else $error("indirect address wrong");
  property p_wreg;
    cmdValid && cmdOp == OP_WREG |=> ramRe
      && ramAddr == {2'h0, $past(workPageRd), $past(cmdArg[3:0])};
  endproperty
  a_wreg: assert property (p_wreg) else $error("working register address wrong");
  property p_imm; immBad |=> immErr && !ramRe && $stable(ramAddr); endproperty
  a_imm: assert property (p_imm) else $error("immediate on memory not refused");
  property p_tabrd; cmdValid && cmdOp == OP_TABRD |=> ramWe && tabNib == $past(tabPick);
  endproperty
  a_tabrd: assert property (p_tabrd) else $error("table nibble wrong");
  property p_resv; romPageRd[3:1] == 3'h0 && !pageRd[3] && !bankRd[3]; endproperty
  a_resv: assert property (p_resv) else $error("reserved bit reads one");
endmodule

// file: tb/mcu_address_generation_unit_bench.sv
// testbench: unit and core end joined by the link, software side over axi4-lite
// assumes the package, the interface and both design modules compiled first
module mcu_address_generation_unit_bench
  import agu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock, nrst, awValid, wValid, bReady, arValid, rReady;
  logic awReady, wReady, bValid, arReady, rValid;
  logic [7:0] awAddr, arAddr;
  logic [31:0] wData, rData;
  logic [3:0] wStrb;
  logic [1:0] bResp, rResp;
  int failCount, checkCount;
  agu_if lnk();
  agu_unit i_agu_unit (.clock(clock), .nrst(nrst), .ce(1'b1), .lnk(lnk.unit));
  agu_core_end i_agu_core_end (.clock(clock), .nrst(nrst), .ce(1'b1),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
    .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
    .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .lnk(lnk.core));
  agu_chk i_agu_chk (.clock(clock), .nrst(nrst), .done(lnk.done), .cmdValid(lnk.cmdValid),
    .cmdOp(lnk.cmdOp),
    .cmdArg(lnk.cmdArg), .romData(lnk.romData), .pc(lnk.pc), .fetchAddr(lnk.fetchAddr),
    .tabAddr(lnk.tabAddr), .tabNib(lnk.tabNib), .ramAddr(lnk.ramAddr), .ramWe(lnk.ramWe),
    .ramRe(lnk.ramRe), .immErr(lnk.immErr), .irqAck(lnk.irqAck), .romPageRd(lnk.romPageRd),
    .pageRd(lnk.pageRd), .workPageRd(lnk.workPageRd), .bankRd(lnk.bankRd));
  always #50 clock = ~clock;
  // --------------------------------------------------------------------
  // shared tasks
  // --------------------------------------------------------------------
  task automatic wrapUp();
    if (failCount == 0 && checkCount > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checkCount++;
    if (got !== exp)
    begin
      failCount++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  // handshakes are judged at the falling edge, acted on at the next rising edge
  task automatic axiWr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    logic aw, w, b;
    awAddr <= a;
    wData <= d;
    awValid <= 1'b1;
    wValid <= 1'b1;
    bReady <= 1'b1;
    for (n = 0; n < 40; n++)
    begin
      @(negedge clock);
      aw = awValid & awReady;
      w = wValid & wReady;
      b = bValid;
      r = bResp;
      @(posedge clock);
      if (aw) awValid <= 1'b0;
      if (w) wValid <= 1'b0;
      if (b) break;
    end
    if (n == 40)
    begin
      failCount++;
      wrapUp();
    end
  endtask
  task automatic axiRd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    logic ar, v;
    arAddr <= a;
    arValid <= 1'b1;
    rReady <= 1'b1;
    for (n = 0; n < 40; n++)
    begin
      @(negedge clock);
      ar = arValid & arReady;
      v = rValid;
      d = rData;
      r = rResp;
      @(posedge clock);
      if (ar) arValid <= 1'b0;
      if (v) break;
    end
    rReady <= 1'b0;
    if (n == 40)
    begin
      failCount++;
      wrapUp();
    end
  endtask
  task automatic rdChk(input logic [7:0] a, input string name, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    axiRd(a, d, r);
    chk(name, exp, d);
  endtask
  task automatic cmd(input agu_op_t op, input logic [13:0] arg);
    logic [1:0] r;
    axiWr(REG_CMD, {14'h0, arg, op}, r);
    @(posedge clock);
  endtask
  // --------------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------------
  task automatic tRom();
    chk("pc", 32'h0, 32'(lnk.pc));
    rdChk(REG_SEL, "sel", 32'h0);
    cmd(OP_SET_ROMPG, 14'h000F);
    chk("rompg", 32'h1, 32'(lnk.romPageRd));
    cmd(OP_JUMP, 14'h07FF);
    chk("pc", 32'h0FFF, 32'(lnk.pc));
    cmd(OP_SET_ROMPG, 14'h0000);
    cmd(OP_CALL, 14'h0123);
    chk("pc", 32'h0123, 32'(lnk.pc));
    cmd(OP_SET_ROMPG, 14'h0001);
    cmd(OP_BRANCH, 14'h0456);
    chk("pc", 32'h0456, 32'(lnk.pc));
    cmd(OP_STEP, 14'h0000);
    rdChk(REG_STAT, "stat", 32'h0457);
  endtask
  // nine calls: the eight newest return addresses must come back in order
  task automatic tStack();
    int k;
    cmd(OP_SET_ROMPG, 14'h0000);
    for (k = 1; k <= 9; k++)
      cmd(OP_CALL, 14'(k));
    for (k = 9; k >= 2; k--)
    begin
      cmd(OP_RET, 14'h0000);
      chk("ret", 32'(k), 32'(lnk.pc));
    end
  endtask
  task automatic tIrq();
    logic [13:0] vec [5] = '{14'h0004, 14'h0008, 14'h000C, 14'h0014, 14'h0020};
    logic [1:0] r;
    int k;
    axiWr(REG_IRQ, 32'h0000_001F, r);
    for (k = 0; k < 5; k++)
    begin
      cmd(OP_INTA, 14'h0000);
      chk("vec", 32'(vec[k]), 32'(lnk.pc));
    end
    cmd(OP_INTA, 14'h0000);
    chk("none", 32'h0021, 32'(lnk.pc));
    for (k = 3; k >= -1; k--)
    begin
      cmd(OP_RET, 14'h0000);
      chk("iret", k < 0 ? 32'h2 : 32'(vec[k]), 32'(lnk.pc));
    end
  endtask
  task automatic tRam();
    logic [31:0] d;
    logic [1:0] r;
    cmd(OP_SET_BANK, 14'h000D);
    cmd(OP_SET_PAGE, 14'h000F);
    cmd(OP_SET_WPAGE, 14'h000F);
    rdChk(REG_SEL, "sel", 32'h5F70);
    cmd(OP_DIRECT, 14'h007F);
    chk("direct", 32'h02FF, 32'(lnk.ramAddr));
    cmd(OP_INDIRECT, 14'h0003);
    chk("indirect", 32'h02F3, 32'(lnk.ramAddr));
    cmd(OP_WREG, 14'h2009);
    chk("wreg", 32'h00F9, 32'(lnk.ramAddr));
    cmd(OP_DIRECT, 14'h2011);
    chk("refused", 32'h00F9, 32'(lnk.ramAddr));
    axiRd(REG_STAT, d, r);
    chk("err", 32'h1, {31'h0, d[16]});
    axiWr(REG_STAT, 32'h0001_0000, r);
    axiRd(REG_STAT, d, r);
    chk("errclr", 32'h0, {31'h0, d[16]});
    axiWr(8'h1C, 32'h0, r);
    chk("bresp", {30'h0, RESP_SLVERR}, {30'h0, r});
    axiRd(8'h18, d, r);
    chk("rresp", {30'h0, RESP_SLVERR}, {30'h0, r});
    chk("rdata", 32'h0, d);
  endtask
  task automatic tTab();
    logic [1:0] r;
    cmd(OP_SET_TAB, 14'h0006);
    cmd(OP_SET_TAB, 14'h001A);
    cmd(OP_SET_TAB, 14'h0025);
    cmd(OP_SET_TAB, 14'h0033);
    chk("tab", 32'h35A6, 32'(lnk.tabAddr));
    axiWr(REG_ROM, 32'h0000_4C21, r);
    cmd(OP_TABRD, 14'h0015);
    rdChk(REG_RAM, "ram", 32'h0003_2956);
  endtask
  initial
  begin
    clock = 1'b0;
    nrst = 1'b0;
    {awValid, wValid, bReady, arValid, rReady} = 5'h00;
    awAddr = 8'h00;
    arAddr = 8'h00;
    wData = 32'h0;
    wStrb = 4'hF;
    failCount = 0;
    checkCount = 0;
    repeat (4) @(posedge clock);
    nrst <= 1'b1;
    repeat (2) @(posedge clock);
    tRom();
    tStack();
    tIrq();
    tRam();
    tTab();
    wrapUp();
  end
endmodule
